/* hdl/count_if.sv */
`timescale 1ns/1ns
interface count_if;
  import timer_pkg::*;
  mode_t mode;
  logic lowEn;
  logic highEn;
  logic wrLow;
  logic wrHigh;
  logic [7:0] wdata;
  logic [7:0] low;
  logic [7:0] high;
  logic ovfLow;
  logic ovfHigh;

  modport unit
  (
    input mode,
    input lowEn,
    input highEn,
    input wrLow,
    input wrHigh,
    input wdata,
    output low,
    output high,
    output ovfLow,
    output ovfHigh
  );

  modport ctrl
  (
    output mode,
    output lowEn,
    output highEn,
    output wrLow,
    output wrHigh,
    output wdata,
    input low,
    input high,
    input ovfLow,
    input ovfHigh
  );
endinterface

/* hdl/count_unit.sv */
`timescale 1ns/1ns
`include "timer_consts.svh"
module count_unit
(
  input wire logic clk_sys,
  input wire logic rst_b,
  count_if.unit cu
);
  import timer_pkg::*;

  logic [7:0] low_q;
  logic [7:0] low_d;
  logic [7:0] high_q;
  logic [7:0] high_d;
  logic ovfLow;
  logic ovfHigh;

  always_comb
  begin
    low_d = low_q;
    high_d = high_q;
    ovfLow = 1'b0;
    ovfHigh = 1'b0;
    if (cu.lowEn)
    begin
      case (cu.mode)
        MODE_13BIT:
        begin
          // Upper three low-byte bits are left alone and carry no meaning
          {high_d, low_d[`SPLIT13_LOW-1:0]} = {high_q, low_q[`SPLIT13_LOW-1:0]} + 13'h0001;
          ovfLow = &{high_q, low_q[`SPLIT13_LOW-1:0]};
        end
        MODE_16BIT:
        begin
          {high_d, low_d} = {high_q, low_q} + 16'h0001;
          ovfLow = &{high_q, low_q};
        end
        MODE_RELOAD:
        begin
          if (&low_q)
          begin
            low_d = high_q;
            ovfLow = 1'b1;
          end
          else
          begin
            low_d = low_q + 8'h01;
          end
        end
        MODE_SPLIT:
        begin
          low_d = low_q + 8'h01;
          ovfLow = &low_q;
        end
        default:
        begin
          low_d = low_q;
        end
      endcase
    end
    if (cu.highEn && (cu.mode == MODE_SPLIT))
    begin
      high_d = high_q + 8'h01;
      ovfHigh = &high_q;
    end
    // Software load wins over a count in the same cycle
    if (cu.wrLow)
    begin
      low_d = cu.wdata;
    end
    if (cu.wrHigh)
    begin
      high_d = cu.wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      low_q <= `RST_BYTE;
      high_q <= `RST_BYTE;
    end
    else
    begin
      low_q <= low_d;
      high_q <= high_d;
    end
  end

  assign cu.low = low_q;
  assign cu.high = high_q;
  assign cu.ovfLow = ovfLow;
  assign cu.ovfHigh = ovfHigh;
endmodule

/* hdl/dual_timer.sv */
// Function
// - Each timer picks timer or counter and one of four modes from its field.
// - Mode 0 counts 13 bits: high byte plus low five bits of low byte.
// - Wrap from all ones to zero sets that timer's overflow flag.
// - Count only when run is set and gate is clear or irq pin high.
// - Setting run keeps count bytes; counting resumes from present value.
// - Both timers have own gate bit, run bit, flag, bytes and pin.
// - Mode 1 is mode 0 but using all sixteen bits.
// - Mode 2 low byte counts, reloads from high byte on overflow, sets flag.
// - Timer 1 in mode 3 holds its count as if stopped.
// - Timer 0 mode 3: low byte is own 8-bit counter with timer 0 controls.
// - Timer 0 mode 3: high byte ticks at clock/12, run1 gates, sets flag1.
`timescale 1ns/1ns
`include "timer_consts.svh"
module dual_timer
#(
  parameter int unsigned TICK_DIV = `TICK_DIV
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic external_irq_pin_zero,
  input wire logic external_irq_pin_one,
  input wire logic timer0_count_input,
  input wire logic timer1_count_input,
  output logic irq
);
  import timer_pkg::*;

  function automatic logic countEvent
  (
    input logic run,
    input logic gate,
    input logic pinLevel,
    input logic counter,
    input logic fallEdge,
    input logic tick
  );
    logic enable;
    enable = run && (!gate || pinLevel);
    countEvent = enable && (counter ? fallEdge : tick);
  endfunction

  // Pin synchronisers; the first stage feeds only the second
  logic [3:0] pinMeta_q;
  logic [3:0] pinMeta_d;
  logic [3:0] pinSync_q;
  logic [3:0] pinSync_d;
  logic [3:0] pinLast_q;
  logic [3:0] pinLast_d;
  logic [3:0] pinFall;

  always_comb
  begin
    pinMeta_d = {timer1_count_input, timer0_count_input, external_irq_pin_one,
      external_irq_pin_zero};
    pinSync_d = pinMeta_q;
    pinLast_d = pinSync_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      pinMeta_q <= `RST_PINS;
      pinSync_q <= `RST_PINS;
      pinLast_q <= `RST_PINS;
    end
    else
    begin
      pinMeta_q <= pinMeta_d;
      pinSync_q <= pinSync_d;
      pinLast_q <= pinLast_d;
    end
  end

  assign pinFall = pinLast_q & ~pinSync_q;

  // Prescaler making the one-in-twelve tick enable
  localparam int unsigned DIV_W = $clog2(TICK_DIV);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic tick;

  assign tick = (div_q == DIV_W'(TICK_DIV - 1));

  always_comb
  begin
    if (tick)
    begin
      div_d = '0;
    end
    else
    begin
      div_d = div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_d;
    end
  end

  // AHB-Lite slave: every transfer has one wait state so writes land before reads
  busPhase_t phase_q;
  busPhase_t phase_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic inRange_q;
  logic inRange_d;
  logic write_q;
  logic write_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic accept;
  logic wrStrobe;
  logic rdStrobe;
  logic [31:0] readMux;

  assign accept = hsel && htrans[1] && hready;
  assign wrStrobe = (phase_q == PH_WAIT) && write_q && inRange_q;
  assign rdStrobe = (phase_q == PH_WAIT) && !write_q;

  always_comb
  begin
    phase_d = phase_q;
    addr_d = addr_q;
    inRange_d = inRange_q;
    write_d = write_q;
    case (phase_q)
      PH_IDLE, PH_DATA:
      begin
        if (accept)
        begin
          phase_d = PH_WAIT;
          addr_d = haddr[7:0];
          inRange_d = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
          write_d = hwrite;
        end
        else
        begin
          phase_d = PH_IDLE;
        end
      end
      PH_WAIT:
      begin
        phase_d = PH_DATA;
      end
      default:
      begin
        phase_d = PH_IDLE;
      end
    endcase
    rdata_d = rdStrobe ? readMux : rdata_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      phase_q <= PH_IDLE;
      addr_q <= `RST_BYTE;
      inRange_q <= 1'b0;
      write_q <= 1'b0;
      rdata_q <= `RST_WORD;
    end
    else
    begin
      phase_q <= phase_d;
      addr_q <= addr_d;
      inRange_q <= inRange_d;
      write_q <= write_d;
      rdata_q <= rdata_d;
    end
  end

  assign hreadyout = (phase_q != PH_WAIT);
  assign hrdata = rdata_q;
  assign hresp = 1'b0;

  // Software-visible control state
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [1:0] run_q;
  logic [1:0] run_d;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic [1:0] flagSet;

  count_if cnt0If();
  count_if cnt1If();

  mode_t mode0;
  mode_t mode1;
  logic ct0;
  logic ct1;
  logic gate0;
  logic gate1;
  logic split0;

  assign mode0 = mode_t'(mode_q[`T0_FIELD+`FLD_MODE +: 2]);
  assign mode1 = mode_t'(mode_q[`T1_FIELD+`FLD_MODE +: 2]);
  assign ct0 = mode_q[`T0_FIELD+`FLD_CT];
  assign ct1 = mode_q[`T1_FIELD+`FLD_CT];
  assign gate0 = mode_q[`T0_FIELD+`FLD_GATE];
  assign gate1 = mode_q[`T1_FIELD+`FLD_GATE];
  assign split0 = (mode0 == MODE_SPLIT);

  // Timer 0 low byte always follows timer 0's own controls, also when split
  assign cnt0If.mode = mode0;
  assign cnt0If.lowEn = countEvent(run_q[`BIT_T0], gate0, pinSync_q[`PIN_IRQ0], ct0,
    pinFall[`PIN_CNT0], tick);
  assign cnt0If.highEn = run_q[`BIT_T1] && tick;
  assign cnt0If.wrLow = wrStrobe && (addr_q == `OFS_T0LO);
  assign cnt0If.wrHigh = wrStrobe && (addr_q == `OFS_T0HI);
  assign cnt0If.wdata = hwdata[7:0];

  assign cnt1If.mode = mode1;
  assign cnt1If.lowEn = countEvent(run_q[`BIT_T1], gate1, pinSync_q[`PIN_IRQ1], ct1,
    pinFall[`PIN_CNT1], tick) && (mode1 != MODE_SPLIT);
  assign cnt1If.highEn = 1'b0;
  assign cnt1If.wrLow = wrStrobe && (addr_q == `OFS_T1LO);
  assign cnt1If.wrHigh = wrStrobe && (addr_q == `OFS_T1HI);
  assign cnt1If.wdata = hwdata[7:0];

  count_unit timer0Unit
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cu(cnt0If.unit)
  );

  count_unit timer1Unit
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cu(cnt1If.unit)
  );

  // With timer 0 split, timer 1 keeps counting but loses its flag to timer 0's high byte
  assign flagSet[`BIT_T0] = cnt0If.ovfLow;
  assign flagSet[`BIT_T1] = split0 ? cnt0If.ovfHigh : cnt1If.ovfLow;

  always_comb
  begin
    mode_d = mode_q;
    run_d = run_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wrStrobe)
    begin
      case (addr_q)
        `OFS_MODE:
        begin
          mode_d = hwdata[7:0];
        end
        `OFS_CTRL:
        begin
          // Run bits only gate counting; bytes are never cleared here
          run_d = hwdata[1:0];
        end
        `OFS_MASK:
        begin
          mask_d = hwdata[1:0];
        end
        `OFS_STAT:
        begin
          stat_d = stat_q & ~hwdata[1:0];
        end
        default:
        begin
          mode_d = mode_q;
        end
      endcase
    end
    // An overflow in the clearing cycle is kept
    stat_d = stat_d | flagSet;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      mode_q <= `RST_BYTE;
      run_q <= `RST_BITS;
      stat_q <= `RST_BITS;
      mask_q <= `RST_BITS;
    end
    else
    begin
      mode_q <= mode_d;
      run_q <= run_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  assign irq = |(stat_q & mask_q);

  always_comb
  begin
    readMux = `RST_WORD;
    if (inRange_q)
    begin
      case (addr_q)
        `OFS_MODE:
        begin
          readMux = {24'h000000, mode_q};
        end
        `OFS_CTRL:
        begin
          readMux = {30'h00000000, run_q};
        end
        `OFS_STAT:
        begin
          readMux = {30'h00000000, stat_q};
        end
        `OFS_MASK:
        begin
          readMux = {30'h00000000, mask_q};
        end
        `OFS_T0LO:
        begin
          readMux = {24'h000000, cnt0If.low};
        end
        `OFS_T0HI:
        begin
          readMux = {24'h000000, cnt0If.high};
        end
        `OFS_T1LO:
        begin
          readMux = {24'h000000, cnt1If.low};
        end
        `OFS_T1HI:
        begin
          readMux = {24'h000000, cnt1If.high};
        end
        `OFS_PINS:
        begin
          readMux = {28'h0000000, pinSync_q};
        end
        default:
        begin
          readMux = `RST_WORD;
        end
      endcase
    end
  end
endmodule

/* hdl/timer_consts.svh */
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_CTRL 8'h04
`define OFS_STAT 8'h08
`define OFS_MASK 8'h0C
`define OFS_T0LO 8'h10
`define OFS_T0HI 8'h14
`define OFS_T1LO 8'h18
`define OFS_T1HI 8'h1C
`define OFS_PINS 8'h20

// Mode register: one nibble per timer
`define T0_FIELD 0
`define T1_FIELD 4
`define FLD_MODE 0
`define FLD_CT 2
`define FLD_GATE 3

// Control, status and mask bit positions
`define BIT_T0 0
`define BIT_T1 1

// Synchronised pin slots
`define PIN_IRQ0 0
`define PIN_IRQ1 1
`define PIN_CNT0 2
`define PIN_CNT1 3

// Reset values
`define RST_BYTE 8'h00
`define RST_BITS 2'h0
`define RST_WORD 32'h0000_0000
// Sync flops reset high so an idle-high pin shows no false fall
`define RST_PINS 4'hF

// Timer tick is one twelfth of the system clock
`define TICK_DIV 12
`define SPLIT13_LOW 5

`endif

/* hdl/timer_pkg.sv */
package timer_pkg;

  typedef enum logic [1:0]
  {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } mode_t;

  typedef enum logic [1:0]
  {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_DATA = 2'b10
  } busPhase_t;

endpackage

/* tb/testbench.sv */
`timescale 1ns/1ns
`include "timer_consts.svh"
module testbench;
  import timer_pkg::*;
  localparam int TK = 3;
  localparam int W = 4 * TK + 6;
  logic clk_sys, rst_b, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic irq0, irq1, cnt0, cnt1;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  assign hready = hreadyout;
  dual_timer #(.TICK_DIV(TK)) dut
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .external_irq_pin_zero(irq0), .external_irq_pin_one(irq1),
    .timer0_count_input(cnt0), .timer1_count_input(cnt1), .irq(irq)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic waitRdy();
    do @(negedge clk_sys); while (hready !== 1'b1);
  endtask
  // Entered just after a rising edge; one single word transfer
  task automatic bus(input logic wr, input logic [11:0] o, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, o};
    hwrite <= wr;
    waitRdy();
    @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    @(posedge clk_sys);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, o, d, x);
  endtask
  task automatic rd(input logic [11:0] o, output logic [31:0] r);
    bus(1'b0, o, 32'h0, r);
  endtask
  task automatic rc(input string nm, input logic [11:0] o, input logic [31:0] e);
    logic [31:0] x;
    rd(o, x);
    check(nm, x, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic clean();
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_STAT, 32'h3);
  endtask
  task automatic tRegs();
    for (int i = 0; i < 8; i++)
      rc("reset", 12'(4 * i), 32'h0);
    rc("pins", `OFS_PINS, 32'h0000000C);
    wr(12'h104, 32'hFF);
    rc("unmapped", 12'h104, 32'h0);
    rc("unmapped", 12'h024, 32'h0);
    wr(`OFS_MODE, 32'h1FF);
    rc("mode", `OFS_MODE, 32'hFF);
    wr(`OFS_T1HI, 32'h1A5);
    rc("t1hi", `OFS_T1HI, 32'hA5);
    wr(`OFS_MODE, 32'h0);
  endtask
  task automatic tMode1();
    clean();
    wr(`OFS_MASK, 32'h1);
    wr(`OFS_T0HI, 32'hFF);
    wr(`OFS_T0LO, 32'hFE);
    wr(`OFS_MODE, 32'h01);
    wr(`OFS_CTRL, 32'h1);
    idle(W);
    wr(`OFS_CTRL, 32'h0);
    rc("stat", `OFS_STAT, 32'h1);
    rc("t0hi", `OFS_T0HI, 32'h0);
    check("irq", irq, 1'b1);
    wr(`OFS_MASK, 32'h0);
    check("irqmask", irq, 1'b0);
    wr(`OFS_MASK, 32'h1);
    wr(`OFS_STAT, 32'h1);
    check("irqclr", irq, 1'b0);
    wr(`OFS_T0LO, 32'h40);
    wr(`OFS_CTRL, 32'h1);
    idle(2 * TK);
    wr(`OFS_CTRL, 32'h0);
    rd(`OFS_T0LO, v);
    check("resume", v > 32'h40 && v < 32'h47, 1'b1);
  endtask
  task automatic tMode0();
    clean();
    wr(`OFS_T0HI, 32'hFF);
    wr(`OFS_T0LO, 32'hFE);
    wr(`OFS_MODE, 32'h00);
    wr(`OFS_CTRL, 32'h1);
    idle(W);
    wr(`OFS_CTRL, 32'h0);
    rc("stat", `OFS_STAT, 32'h1);
    rc("t0hi", `OFS_T0HI, 32'h0);
    rd(`OFS_T0LO, v);
    check("t0lo", v[4:0] < 5'h08, 1'b1);
  endtask
  task automatic tReload();
    clean();
    wr(`OFS_T1HI, 32'hF0);
    wr(`OFS_T1LO, 32'hFE);
    wr(`OFS_T0HI, 32'hE0);
    wr(`OFS_T0LO, 32'hFE);
    wr(`OFS_MODE, 32'h22);
    wr(`OFS_CTRL, 32'h3);
    idle(W);
    wr(`OFS_CTRL, 32'h0);
    rc("stat", `OFS_STAT, 32'h3);
    rc("t1hi", `OFS_T1HI, 32'hF0);
    rc("t0hi", `OFS_T0HI, 32'hE0);
    rd(`OFS_T1LO, v);
    check("t1lo", v >= 32'hF0 && v < 32'hF6, 1'b1);
    rd(`OFS_T0LO, v);
    check("t0lo", v >= 32'hE0 && v < 32'hE6, 1'b1);
  endtask
  task automatic tGate();
    clean();
    wr(`OFS_T0LO, 32'h0);
    wr(`OFS_T1LO, 32'h0);
    wr(`OFS_MODE, 32'h91);
    wr(`OFS_CTRL, 32'h3);
    idle(W);
    rc("gated", `OFS_T1LO, 32'h0);
    rd(`OFS_T0LO, v);
    check("t0free", v != 32'h0, 1'b1);
    irq1 <= 1'b1;
    idle(W);
    rd(`OFS_T1LO, v);
    check("open", v != 32'h0, 1'b1);
    irq1 <= 1'b0;
    wr(`OFS_MODE, 32'h19);
    wr(`OFS_T0LO, 32'h0);
    idle(W);
    rc("gated0", `OFS_T0LO, 32'h0);
  endtask
  task automatic fall0(input int n);
    repeat (n)
    begin
      cnt0 <= 1'b0;
      cnt1 <= 1'b0;
      idle(4);
      cnt0 <= 1'b1;
      cnt1 <= 1'b1;
      idle(4);
    end
  endtask
  task automatic tCount();
    clean();
    wr(`OFS_T0LO, 32'h0);
    wr(`OFS_T0HI, 32'h0);
    wr(`OFS_T1LO, 32'h0);
    wr(`OFS_MODE, 32'h55);
    wr(`OFS_CTRL, 32'h3);
    fall0(5);
    rc("events", `OFS_T0LO, 32'h5);
    rc("events1", `OFS_T1LO, 32'h5);
  endtask
  task automatic tSplit();
    clean();
    wr(`OFS_T1LO, 32'h07);
    wr(`OFS_T0LO, 32'hFF);
    wr(`OFS_T0HI, 32'hFF);
    wr(`OFS_MODE, 32'h37);
    wr(`OFS_CTRL, 32'h3);
    fall0(1);
    idle(W);
    wr(`OFS_CTRL, 32'h0);
    rc("t1hold", `OFS_T1LO, 32'h07);
    rc("t0lo", `OFS_T0LO, 32'h0);
    rc("stat", `OFS_STAT, 32'h3);
    rd(`OFS_T0HI, v);
    check("t0hi", v < 32'h0A, 1'b1);
  endtask
  initial
  begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    irq0 = 1'b0;
    irq1 = 1'b0;
    cnt0 = 1'b1;
    cnt1 = 1'b1;
    idle(16);
    rst_b <= 1'b1;
    idle(2);
    tRegs();
    tMode1();
    tMode0();
    tReload();
    tGate();
    tCount();
    tSplit();
    final_report();
  end
endmodule

/* tb/timer_props.sv */
`timescale 1ns/1ns
module timer_props
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic irq
);
  logic take;
  logic done;
  logic unmap;
  logic rdPend_q;
  logic rdPend_d;
  logic [31:0] rdAddr_q;
  logic [31:0] rdAddr_d;
  assign take = hsel && htrans[1] && hready;
  assign done = rdPend_q && hreadyout;
  assign unmap = (rdAddr_q[31:8] != 24'h0) || (rdAddr_q[1:0] != 2'h0) || (rdAddr_q[7:0] > 8'h20);
  always_comb
  begin
    rdPend_d = take ? !hwrite : (hreadyout ? 1'b0 : rdPend_q);
    rdAddr_d = take ? haddr : rdAddr_q;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rdPend_q <= 1'b0;
      rdAddr_q <= 32'h0;
    end
    else
    begin
      rdPend_q <= rdPend_d;
      rdAddr_q <= rdAddr_d;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
  AST_ONE_WAIT: assert property (take |=> !hreadyout ##1 hreadyout) else $error("wait not one");
  AST_IDLE_READY: assert property (hreadyout && !take |=> hreadyout) else $error("stray wait");
  AST_RDATA_HOLD: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("hrdata moved outside read");
  AST_RESET: assert property (disable iff (1'b0) !rst_b |=> hreadyout && hrdata == 32'h0 && !irq)
    else $error("outputs not reset");
  AST_UNMAPPED: assert property (done && unmap |-> hrdata == 32'h0) else $error("unmapped not 0");
  AST_BYTE_WIDTH: assert property (done |-> hrdata[31:8] == 24'h0)
    else $error("read wider than byte");
  AST_BIT_REGS: assert property (done && rdAddr_q[7:0] inside {8'h04, 8'h08, 8'h0C}
    && !unmap |-> hrdata[31:2] == 30'h0) else $error("flag reg too wide");
  AST_IRQ_DROP: assert property ($fell(irq) |-> !$past(hreadyout))
    else $error("irq fell without a write");
  C_WRITE: cover property (take && hwrite);
  C_READ: cover property (done && !unmap);
  C_IRQ: cover property ($rose(irq));
endmodule
bind dual_timer timer_props u_props
(
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hrdata(hrdata),
  .hresp(hresp),
  .irq(irq)
);
